// *** core/crm_pkg.sv ***
// constants and types shared by the clock, reset and mode-pin block
// assumes a single 50 MHz system clock and a synchronous active-high reset
package crm_pkg;

    // address of the first opcode fetch after reset
    localparam logic [19:0] CRM_FETCH_ADDR   = 20'hFFFF0;
    // vector type serviced for the non-maskable interrupt
    localparam logic [7:0]  CRM_NMI_TYPE     = 8'h02;

    // positions of the pin inputs inside the synchroniser vector
    localparam int          CRM_SYNC_W       = 5;
    localparam int          CRM_IDX_CLK      = 0;
    localparam int          CRM_IDX_RES      = 1;
    localparam int          CRM_IDX_NMI      = 2;
    localparam int          CRM_IDX_TEST     = 3;
    localparam int          CRM_IDX_A19      = 4;
    // reset value of the synchronised pins: clock, request and nmi low, test and strap high;
    // the request reads as held until the pin says otherwise, so the fill is no false release
    localparam logic [4:0]  CRM_SYNC_RST     = 5'h18;

    // reset values of the timing output and the strap sample
    localparam logic        CRM_HALF_RST     = 1'b0;
    localparam logic        CRM_STRAP_RST    = 1'b1;

    // reset sequencing: request held, realign the timing output, running
    typedef enum logic [1:0] {RST_ACTIVE, RST_ALIGN, RST_RUN} crm_rst_e;
    // power sequencing: running, powered down, waiting on the delay pin
    typedef enum logic [1:0] {PWR_RUN, PWR_DOWN, PWR_WAKE} crm_pwr_e;

endpackage

// *** core/crm_sync3.sv ***
// three-stage synchroniser with agreement filter for asynchronous pins
// assumes every bit is an independent level from outside the clock domain
`timescale 1ns/100ps
module crm_sync3
    import crm_pkg::*;
#(
    parameter int W = CRM_SYNC_W
) (
    // clock and reset
    input  wire logic         sys_clk,
    input  wire logic         sys_rst,
    // raw pins
    input  wire logic [W-1:0] pinIn,
    // filtered level and one-cycle edge pulses
    output logic [W-1:0]      level,
    output logic [W-1:0]      rise,
    output logic [W-1:0]      fall
);

    logic [W-1:0] stage1;
    logic [W-1:0] stage2;
    logic [W-1:0] stage3;
    logic [W-1:0] agree;
    logic [W-1:0] next_level;
    logic [W-1:0] next_rise;
    logic [W-1:0] next_fall;

    // a change counts only when stages two and three agree; stage one feeds stage two only
    always_comb begin
        agree      = ~(stage2 ^ stage3);
        next_level = (agree & stage3) | (~agree & level);
        next_rise  = next_level & ~level;
        next_fall  = ~next_level & level;
    end

    // register the chain and the filtered result
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            stage1 <= CRM_SYNC_RST[W-1:0];
            stage2 <= CRM_SYNC_RST[W-1:0];
            stage3 <= CRM_SYNC_RST[W-1:0];
            level  <= CRM_SYNC_RST[W-1:0];
            rise   <= '0;
            fall   <= '0;
        end else begin
            stage1 <= pinIn;
            stage2 <= stage1;
            stage3 <= stage2;
            level  <= next_level;
            rise   <= next_rise;
            fall   <= next_fall;
        end
    end

endmodule

// *** core/crm_clock_reset_mode.sv ***
// clock divider, reset sequencing, powerdown delay, nmi latch, wait release
// and the shared address-19 / status / strap pin of the processor
// assumes all pins are asynchronous to sys_clk and the cpu core shares sys_clk
`timescale 1ns/100ps
module crm_clock_reset_mode
    import crm_pkg::*;
(
    // system clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // asynchronous pins
    input  wire logic        doubleRateClockIn,
    input  wire logic        resetRequestInN,
    input  wire logic        nmiIn,
    input  wire logic        testBusyInN,
    // cpu core side
    input  wire logic        waitInstrActive,
    input  wire logic        nmiServiced,
    input  wire logic        busAddrPhase,
    input  wire logic        busStatusPhase,
    input  wire logic        cpuAddr19,
    input  wire logic        dmaOrRefreshCycle,
    // power management requests
    input  wire logic        powerdownRequest,
    input  wire logic        wakeEvent,
    // timing output pin
    output logic             halfRateTimingOut,
    output logic             halfRateTimingOe,
    // reset indicator pin and core controls
    output logic             resetIndicatorOut,
    output logic             resetIndicatorOe,
    output logic             busAbort,
    output logic             fetchStart,
    output logic [19:0]      fetchAddr,
    // powerdown delay pin
    input  wire logic        powerdownDelayIn,
    output logic             powerdownDelayOut,
    output logic             powerdownDelayOe,
    output logic             powerdownDelayPullUp,
    output logic             clocksRunning,
    output logic             oscEnable,
    // interrupt and wait
    output logic             nmiPending,
    output logic [7:0]       nmiVector,
    output logic             waitStall,
    output logic             coprocBusy,
    // shared address-19 / status / strap pin
    input  wire logic        addr19StatusStrapIn,
    output logic             addr19StatusStrapOut,
    output logic             addr19StatusStrapOe,
    output logic             addr19StatusStrapPullUp,
    output logic             pinFloatTestMode
);

    logic [CRM_SYNC_W-1:0] syncLevel;
    logic [CRM_SYNC_W-1:0] syncRise;
    logic [CRM_SYNC_W-1:0] syncFall;
    logic                  clkFall;
    logic                  reqActive;

    crm_rst_e              rstState;
    crm_rst_e              next_rstState;
    crm_pwr_e              pwrState;
    crm_pwr_e              next_pwrState;
    logic                  strapSample;
    logic                  next_strapSample;
    logic                  next_halfRateTimingOut;
    logic                  next_fetchStart;
    logic                  next_pinFloatTestMode;
    logic                  next_nmiPending;
    logic                  next_addr19StatusStrapOut;

    // all pins but the powerdown delay pin pass one shared synchroniser
    crm_sync3 #(
        .W      (CRM_SYNC_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .sys_rst(sys_rst),
        .pinIn  ({addr19StatusStrapIn, testBusyInN, nmiIn, resetRequestInN,
                  doubleRateClockIn}),
        .level  (syncLevel),
        .rise   (syncRise),
        .fall   (syncFall)
    );

    assign clkFall   = syncFall[CRM_IDX_CLK];
    assign reqActive = ~syncLevel[CRM_IDX_RES];

    // reset sequencing and strap capture
    always_comb begin
        next_rstState         = rstState;
        next_strapSample      = strapSample;
        next_pinFloatTestMode = pinFloatTestMode;
        next_fetchStart       = 1'b0;
        unique case (rstState)
            RST_ACTIVE: begin
                next_strapSample = syncLevel[CRM_IDX_A19];
                if (!reqActive) begin
                    next_rstState         = RST_ALIGN;
                    next_pinFloatTestMode = ~strapSample;
                end
            end
            RST_ALIGN: begin
                if (clkFall) begin
                    next_rstState   = RST_RUN;
                    next_fetchStart = 1'b1;
                end
            end
            RST_RUN: begin
                next_rstState = RST_RUN;
            end
        endcase
        if (reqActive) begin
            next_rstState   = RST_ACTIVE;
            next_fetchStart = 1'b0;
        end
    end

    // power sequencing; a reset request always returns to running
    always_comb begin
        next_pwrState = pwrState;
        unique case (pwrState)
            PWR_RUN: begin
                if (powerdownRequest && rstState == RST_RUN) begin
                    next_pwrState = PWR_DOWN;
                end
            end
            PWR_DOWN: begin
                if (wakeEvent) begin
                    next_pwrState = PWR_WAKE;
                end
            end
            PWR_WAKE: begin
                if (powerdownDelayIn) begin
                    next_pwrState = PWR_RUN;
                end
            end
        endcase
        if (reqActive) begin
            next_pwrState = PWR_RUN;
        end
    end

    // divider, nmi latch and shared-pin value
    always_comb begin
        next_halfRateTimingOut = halfRateTimingOut;
        if (clkFall && pwrState == PWR_RUN) begin
            next_halfRateTimingOut = ~halfRateTimingOut;
        end
        // low until the first fall after release, high on it
        if (rstState == RST_ALIGN) begin
            next_halfRateTimingOut = clkFall;
        end
        // edge latch, set wins over clear
        next_nmiPending = syncRise[CRM_IDX_NMI] | (nmiPending & ~nmiServiced);
        if (reqActive) begin
            next_nmiPending = 1'b0;
        end
        // address in address phase, status after
        next_addr19StatusStrapOut = addr19StatusStrapOut;
        if (busAddrPhase) begin
            next_addr19StatusStrapOut = cpuAddr19;
        end else if (busStatusPhase) begin
            next_addr19StatusStrapOut = dmaOrRefreshCycle;
        end
    end

    // state registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            rstState             <= RST_ACTIVE;
            pwrState             <= PWR_RUN;
            strapSample          <= CRM_STRAP_RST;
            pinFloatTestMode     <= 1'b0;
            halfRateTimingOut    <= CRM_HALF_RST;
            fetchStart           <= 1'b0;
            nmiPending           <= 1'b0;
            addr19StatusStrapOut <= 1'b0;
        end else begin
            rstState             <= next_rstState;
            pwrState             <= next_pwrState;
            strapSample          <= next_strapSample;
            pinFloatTestMode     <= next_pinFloatTestMode;
            halfRateTimingOut    <= next_halfRateTimingOut;
            fetchStart           <= next_fetchStart;
            nmiPending           <= next_nmiPending;
            addr19StatusStrapOut <= next_addr19StatusStrapOut;
        end
    end

    // pin drivers and core controls, all registered
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            resetIndicatorOut       <= 1'b1;
            resetIndicatorOe        <= 1'b1;
            busAbort                <= 1'b1;
            halfRateTimingOe        <= 1'b1;
            fetchAddr               <= CRM_FETCH_ADDR;
            powerdownDelayOut       <= 1'b0;
            powerdownDelayOe        <= 1'b0;
            powerdownDelayPullUp    <= 1'b1;
            clocksRunning           <= 1'b1;
            oscEnable               <= 1'b1;
            nmiVector               <= 8'h00;
            waitStall               <= 1'b0;
            coprocBusy              <= 1'b0;
            addr19StatusStrapOe     <= 1'b0;
            addr19StatusStrapPullUp <= 1'b1;
        end else begin
            resetIndicatorOut       <= reqActive;
            resetIndicatorOe        <= ~next_pinFloatTestMode;
            halfRateTimingOe        <= ~next_pinFloatTestMode;
            busAbort                <= reqActive;
            fetchAddr               <= CRM_FETCH_ADDR;
            // discharge in powerdown, weak pull otherwise unless reset is requested; neither in float mode
            powerdownDelayOut       <= 1'b0;
            powerdownDelayOe        <= next_pwrState == PWR_DOWN && !next_pinFloatTestMode;
            powerdownDelayPullUp    <= next_pwrState != PWR_DOWN && !reqActive
                                       && !next_pinFloatTestMode;
            clocksRunning           <= next_pwrState == PWR_RUN;
            oscEnable               <= next_pwrState != PWR_DOWN;
            nmiVector               <= next_nmiPending ? CRM_NMI_TYPE : 8'h00;
            waitStall               <= waitInstrActive && syncLevel[CRM_IDX_TEST];
            coprocBusy              <= syncLevel[CRM_IDX_TEST];
            // float in reset; and in float mode
            addr19StatusStrapOe     <= next_rstState == RST_RUN && !next_pinFloatTestMode;
            addr19StatusStrapPullUp <= reqActive;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_half_toggle;
        clkFall && pwrState == PWR_RUN && rstState == RST_RUN |=> $changed(halfRateTimingOut);
    endproperty
    a_half_toggle: assert property (p_half_toggle) else $error("timing output missed a fall");
    property p_abort;
        reqActive |=> busAbort && rstState == RST_ACTIVE && !fetchStart;
    endproperty
    a_abort: assert property (p_abort) else $error("reset did not abort the bus");
    property p_ind_on;
        reqActive |=> resetIndicatorOut;
    endproperty
    a_ind_on: assert property (p_ind_on) else $error("indicator low during reset");
    // the indicator lags the request by one edge, so look one edge after two held cycles
    property p_ind_hold;
        reqActive ##1 reqActive |=> resetIndicatorOut && $past(resetIndicatorOut);
    endproperty
    a_ind_hold: assert property (p_ind_hold) else $error("indicator dropped early");
    property p_fetch;
        fetchStart |-> $past(rstState) == RST_ALIGN && halfRateTimingOut
                       && fetchAddr == CRM_FETCH_ADDR;
    endproperty
    a_fetch: assert property (p_fetch) else $error("fetch without realignment");
    property p_pd_wait;
        pwrState == PWR_WAKE && !powerdownDelayIn && !reqActive |=> !clocksRunning;
    endproperty
    a_pd_wait: assert property (p_pd_wait) else $error("resumed before delay pin");
    property p_nmi;
        syncRise[CRM_IDX_NMI] && !reqActive |=> nmiPending && nmiVector == CRM_NMI_TYPE;
    endproperty
    a_nmi: assert property (p_nmi) else $error("nmi edge not latched");
    property p_wait;
        waitInstrActive && syncLevel[CRM_IDX_TEST] |=> waitStall;
    endproperty
    a_wait: assert property (p_wait) else $error("wait did not stall");
    property p_a19;
        busAddrPhase |=> addr19StatusStrapOut == $past(cpuAddr19);
    endproperty
    a_a19: assert property (p_a19) else $error("address bit 19 not driven");
    property p_s6;
        !busAddrPhase && busStatusPhase |=> addr19StatusStrapOut == $past(dmaOrRefreshCycle);
    endproperty
    a_s6: assert property (p_s6) else $error("cycle source status wrong");
    property p_strap_float;
        reqActive |=> !addr19StatusStrapOe ##1 (!addr19StatusStrapOe || !reqActive);
    endproperty
    a_strap_float: assert property (p_strap_float) else $error("shared pin driven in reset");
    property p_pin_float_test_mode;
        rstState == RST_ACTIVE && !reqActive |=> pinFloatTestMode == !$past(strapSample);
    endproperty
    a_pin_float_test_mode: assert property (p_pin_float_test_mode) else $error("strap not captured at release");
    // enables are registered from the same next value as the mode, so they agree each cycle
    property p_pin_float_test_mode_float;
        pinFloatTestMode |-> !halfRateTimingOe && !resetIndicatorOe && !addr19StatusStrapOe;
    endproperty
    a_pin_float_test_mode_float: assert property (p_pin_float_test_mode_float) else $error("pin driven in float mode");
    property p_pullup;
        reqActive |=> addr19StatusStrapPullUp;
    endproperty
    a_pullup: assert property (p_pullup) else $error("no pull-up during reset");
    property p_pd_clk;
        pwrState == PWR_DOWN && !wakeEvent && !reqActive |=> !clocksRunning && !oscEnable;
    endproperty
    a_pd_clk: assert property (p_pd_clk) else $error("clocks running in powerdown");
    property p_keep;
        rstState == RST_RUN && !reqActive |=> $stable(pinFloatTestMode);
    endproperty
    a_keep: assert property (p_keep) else $error("float mode changed outside reset");

    c_fetch: cover property (fetchStart);
    c_pin_float_test_mode: cover property (rstState == RST_ALIGN && pinFloatTestMode);
    c_wake: cover property (pwrState == PWR_WAKE ##1 pwrState == PWR_RUN);
    c_nmi: cover property (nmiPending && nmiServiced);

endmodule

// *** sim/crm_board_model.sv ***
// board-side partner: input clock source, reset supervisor, strap and delay pin
// assumes the bench commands the reset request and the strap pull-down
`timescale 1ns/100ps
module crm_board_model #(
    parameter int HALF_NS    = 131,
    parameter int CHARGE_CYC = 40
) (
    // clock and bench commands
    input  wire logic sys_clk,
    input  wire logic resetCmdN,
    input  wire logic strapLowCmd,
    // device drives
    input  wire logic oscEnable,
    input  wire logic addr19StatusStrapOut,
    input  wire logic addr19StatusStrapOe,
    input  wire logic addr19StatusStrapPullUp,
    input  wire logic powerdownDelayOut,
    input  wire logic powerdownDelayOe,
    input  wire logic powerdownDelayPullUp,
    // resolved pin levels
    output logic      doubleRateClockIn,
    output logic      resetRequestInN,
    output logic      addr19StatusStrapIn,
    output logic      powerdownDelayIn
);
    int   chargeCnt = 0;
    logic lastStrap = 1'b1;

    // oscillator stands still low while disabled; period not locked to sys_clk
    initial begin
        doubleRateClockIn = 1'b0;
        forever begin
            #(HALF_NS);
            doubleRateClockIn = oscEnable ? ~doubleRateClockIn : 1'b0;
        end
    end

    // supervisor passes the commanded request straight to the pin
    assign resetRequestInN = resetCmdN;

    // strap wire: drive, then board pull-down, then weak pull-up
    always_comb begin
        if (addr19StatusStrapOe)
            addr19StatusStrapIn = addr19StatusStrapOut;
        else if (strapLowCmd)
            addr19StatusStrapIn = 1'b0;
        else if (addr19StatusStrapPullUp)
            addr19StatusStrapIn = 1'b1;
        else
            addr19StatusStrapIn = ~lastStrap; // floating: never a stale level
    end

    // capacitor discharged by the device, recharged slowly via pull-up
    always_ff @(posedge sys_clk) begin
        lastStrap <= addr19StatusStrapIn;
        if (powerdownDelayOe && !powerdownDelayOut)
            chargeCnt <= 0;
        else if (powerdownDelayPullUp && chargeCnt < CHARGE_CYC)
            chargeCnt <= chargeCnt + 1;
    end
    assign powerdownDelayIn = (chargeCnt >= CHARGE_CYC);
endmodule

// *** sim/clock_reset_mode_pins_tb.sv ***
// self-checking bench for the clock, reset and mode-pin block
// assumes the board model supplies input clock, reset request and pin levels
`timescale 1ns/100ps
module clock_reset_mode_pins_tb
    import crm_pkg::*;
;
    logic sys_clk, sys_rst, resetCmdN, strapLowCmd, nmiIn, testBusyInN, nmiServiced;
    logic waitInstrActive, busAddrPhase, busStatusPhase, cpuAddr19, dmaOrRefreshCycle;
    logic powerdownRequest, wakeEvent, doubleRateClockIn, resetRequestInN;
    logic halfRateTimingOut, halfRateTimingOe, resetIndicatorOut, resetIndicatorOe;
    logic busAbort, fetchStart, powerdownDelayIn, powerdownDelayOut, powerdownDelayOe;
    logic powerdownDelayPullUp, clocksRunning, oscEnable, nmiPending, waitStall;
    logic coprocBusy, addr19StatusStrapIn, addr19StatusStrapOut, addr19StatusStrapOe;
    logic addr19StatusStrapPullUp, pinFloatTestMode, prevPending, last;
    logic [19:0] fetchAddr;
    logic [7:0]  nmiVector;
    logic [19:0] fetchQ[$];
    logic [7:0]  nmiQ[$];
    logic [31:0] rngState = 32'h0000C6D9;
    logic [31:0] r;
    int          miscompares = 0;
    int          n_checks = 0;
    int          tog;
    int          run;

    crm_board_model crm_board_model_inst (.sys_clk, .resetCmdN, .strapLowCmd, .oscEnable,
        .addr19StatusStrapOut, .addr19StatusStrapOe, .addr19StatusStrapPullUp,
        .powerdownDelayOut, .powerdownDelayOe, .powerdownDelayPullUp, .doubleRateClockIn,
        .resetRequestInN, .addr19StatusStrapIn, .powerdownDelayIn);

    crm_clock_reset_mode crm_clock_reset_mode_inst (.sys_clk, .sys_rst, .doubleRateClockIn,
        .resetRequestInN, .nmiIn, .testBusyInN, .waitInstrActive, .nmiServiced, .busAddrPhase,
        .busStatusPhase, .cpuAddr19, .dmaOrRefreshCycle, .powerdownRequest, .wakeEvent,
        .halfRateTimingOut, .halfRateTimingOe, .resetIndicatorOut, .resetIndicatorOe,
        .busAbort, .fetchStart, .fetchAddr, .powerdownDelayIn, .powerdownDelayOut,
        .powerdownDelayOe, .powerdownDelayPullUp, .clocksRunning, .oscEnable, .nmiPending,
        .nmiVector, .waitStall, .coprocBusy, .addr19StatusStrapIn, .addr19StatusStrapOut,
        .addr19StatusStrapOe, .addr19StatusStrapPullUp, .pinFloatTestMode);

    // 50 MHz system clock
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] nextRand();
        rngState ^= rngState << 13;
        rngState ^= rngState >> 17;
        rngState ^= rngState << 5;
        return rngState;
    endfunction

    task automatic chk(input logic ok, input string msg);
        n_checks++;
        if (ok !== 1'b1) begin
            miscompares++;
            $display("[ERR] %0t %s", $time, msg);
        end
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // bounded wait; a wait that runs out ends the run
    task automatic waitSig(ref logic s, input logic v, input int lim, input string msg);
        int n;
        n = 0;
        while (s !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
        if (s !== v) begin
            chk(1'b0, msg);
            report_and_stop();
        end
    endtask

    // watcher: every result takes the oldest note; a result with no note is a mismatch
    always @(posedge sys_clk) begin
        if (fetchStart === 1'b1 && fetchQ.size() == 0)
            chk(1'b0, "unexpected fetch");
        else if (fetchStart === 1'b1)
            chk(fetchAddr === fetchQ.pop_front() && halfRateTimingOut === 1'b1, "fetch");
        if (nmiPending === 1'b1 && prevPending !== 1'b1 && nmiQ.size() == 0)
            chk(1'b0, "unexpected nmi");
        else if (nmiPending === 1'b1 && prevPending !== 1'b1)
            chk(nmiVector === nmiQ.pop_front(), "nmi vector");
        prevPending <= nmiPending;
    end

    // cut a hang short
    initial begin
        #1000000;
        chk(1'b0, "run limit");
        report_and_stop();
    end

    // main sequence
    initial begin
        {sys_rst, testBusyInN} = 2'h3;
        {resetCmdN, strapLowCmd, nmiIn, nmiServiced, waitInstrActive} = 5'h00;
        {busAddrPhase, busStatusPhase, cpuAddr19, dmaOrRefreshCycle} = 4'h0;
        {powerdownRequest, wakeEvent} = 2'h0;
        cyc(16);
        sys_rst <= 1'b0;
        cyc(8);
        repeat (30) begin
            @(posedge sys_clk);
            chk(resetIndicatorOut === 1'b1 && busAbort === 1'b1, "reset outputs");
            chk(addr19StatusStrapOe === 1'b0 && addr19StatusStrapPullUp === 1'b1, "strap");
        end
        fetchQ.push_back(20'hFFFF0);
        resetCmdN <= 1'b1;
        waitSig(fetchStart, 1'b1, 40, "first fetch");
        chk(pinFloatTestMode === 1'b0 && resetIndicatorOut === 1'b0, "release");
        // every high and low phase spans one input period (13.1 cycles)
        tog = 0;
        run = 0;
        last = halfRateTimingOut;
        repeat (300) begin
            @(posedge sys_clk);
            if (halfRateTimingOut !== last) begin
                if (tog > 0) chk(run >= 12 && run <= 14, "half-rate phase");
                tog++;
                run = 0;
            end
            run++;
            last = halfRateTimingOut;
        end
        chk(tog >= 20, "half-rate toggles");
        repeat (16) begin
            r = nextRand();
            @(posedge sys_clk);
            busAddrPhase <= 1'b1;
            cpuAddr19 <= r[0];
            dmaOrRefreshCycle <= r[1];
            @(posedge sys_clk);
            busAddrPhase <= 1'b0;
            busStatusPhase <= 1'b1;
            @(posedge sys_clk);
            busStatusPhase <= 1'b0;
            chk(addr19StatusStrapIn === r[0] && addr19StatusStrapOe === 1'b1, "a19");
            @(posedge sys_clk);
            chk(addr19StatusStrapOut === r[1], "cycle source");
        end
        nmiQ.push_back(8'h02);
        nmiIn <= 1'b1;
        waitSig(nmiPending, 1'b1, 8, "nmi lost");
        nmiIn <= 1'b0;
        cyc(10);
        chk(nmiPending === 1'b1 && nmiVector === 8'h02, "nmi latch");
        nmiServiced <= 1'b1;
        cyc(1);
        nmiServiced <= 1'b0;
        cyc(2);
        chk(nmiPending === 1'b0 && nmiVector === 8'h00, "nmi clear");
        waitInstrActive <= 1'b1;
        cyc(6);
        chk(waitStall === 1'b1 && coprocBusy === 1'b1, "wait stall");
        testBusyInN <= 1'b0;
        waitSig(waitStall, 1'b0, 8, "wait stuck");
        chk(coprocBusy === 1'b0, "busy level");
        waitInstrActive <= 1'b0;
        testBusyInN <= 1'b1;
        powerdownRequest <= 1'b1;
        waitSig(clocksRunning, 1'b0, 4, "no powerdown");
        powerdownRequest <= 1'b0;
        chk(oscEnable === 1'b0 && powerdownDelayOe === 1'b1, "powerdown pins");
        cyc(4);
        wakeEvent <= 1'b1;
        cyc(1);
        wakeEvent <= 1'b0;
        waitSig(powerdownDelayIn, 1'b1, 100, "delay pin low");
        chk(clocksRunning === 1'b0, "early resume");
        waitSig(clocksRunning, 1'b1, 4, "no resume");
        // reset in mid-run with a pending nmi and the strap held low
        nmiQ.push_back(8'h02);
        nmiIn <= 1'b1;
        waitSig(nmiPending, 1'b1, 8, "second nmi lost");
        nmiIn <= 1'b0;
        resetCmdN <= 1'b0;
        strapLowCmd <= 1'b1;
        waitSig(busAbort, 1'b1, 8, "no abort");
        cyc(1);
        chk(nmiPending === 1'b0 && resetIndicatorOut === 1'b1, "init state");
        fetchQ.push_back(20'hFFFF0);
        cyc(10);
        resetCmdN <= 1'b1;
        waitSig(fetchStart, 1'b1, 40, "second fetch");
        strapLowCmd <= 1'b0;
        chk(pinFloatTestMode === 1'b1, "float mode");
        busAddrPhase <= 1'b1;
        cyc(3);
        busAddrPhase <= 1'b0;
        chk(halfRateTimingOe === 1'b0 && resetIndicatorOe === 1'b0, "float oe");
        chk(addr19StatusStrapOe === 1'b0, "float strap");
        chk(fetchQ.size() == 0 && nmiQ.size() == 0, "results missing");
        report_and_stop();
    end
endmodule
